// ===== adcsq_map.vh
// constants for the converter sequencing control block
`ifndef ADCSQ_MAP_VH
`define ADCSQ_MAP_VH
`define ADCSQ_SETTLE_DIV 2'h3
`define ADCSQ_SETTLE_RST 8'h40
`define ADCSQ_SETTLE_NS 16000
`define ADCSQ_CLK_MHZ 250
`define ADCSQ_RAW_W 10
`define ADCSQ_RES_W 16
`define ADCSQ_CONV_TMO 16'hFFFF
`endif

// ===== adcsq_sync3.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module adcsq_sync3 #(
   parameter W = 1
) (
   // clock and reset
   input wire i_clk,
   input wire i_rst,
   // data
   input wire [W-1:0] i_d,
   output reg [W-1:0] o_q
);
   reg [W-1:0] s1_ff;
   reg [W-1:0] s2_ff;
   reg [W-1:0] s3_ff;
   // first stage read only by second; value taken when stages two and three agree
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_ff <= {W{1'b0}};
         s2_ff <= {W{1'b0}};
         s3_ff <= {W{1'b0}};
         o_q <= {W{1'b0}};
      end else begin
         s1_ff <= i_d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            o_q <= s3_ff;
         end
      end
   end
endmodule // adcsq_sync3

// ===== adcsq_top.v
// converter sequencing control: power-up, settle delay, manual conversion, results
`timescale 1ns/10ps
`include "adcsq_map.vh"
module adcsq_top #(
   parameter SETTLE_W = 8,
   parameter TMO_W = 16
) (
   // clock and reset
   input wire I_CLK_SYS,
   input wire I_SYS_RST,
   // software control, plain ports on the system clock instead of a bus
   input wire I_CONVERTER_POWER_ON,
   input wire [SETTLE_W-1:0] I_REGULATOR_SETTLE_COUNT,
   input wire I_CONVERSION_GO_WR,
   input wire I_DONE_FLAG_CLR,
   input wire I_IRQ_MASK,
   input wire I_DMA_ENABLE,
   input wire [2:0] I_CHANNEL_SELECT,
   input wire I_SINGLE_ENDED_SELECT,
   input wire [1:0] I_INPUT_ATTENUATION,
   input wire I_LEVEL_SHIFTER_ON,
   input wire [3:0] I_SHIFTER_COMMON_MODE,
   // analog core
   input wire I_CORE_DONE,
   input wire [`ADCSQ_RAW_W-1:0] I_CORE_DATA,
   output reg O_REGULATOR_EN,
   output reg O_CONVERTER_EN,
   output reg O_CORE_START,
   output reg [2:0] O_CHANNEL_SELECT,
   output reg O_SINGLE_ENDED_SELECT,
   output reg [1:0] O_INPUT_ATTENUATION,
   output reg O_LEVEL_SHIFTER_ON,
   output reg [3:0] O_SHIFTER_COMMON_MODE,
   // status toward software
   output reg O_CONVERSION_GO,
   output reg O_CONVERSION_DONE_FLAG,
   output reg O_READY,
   output reg O_TIMEOUT,
   output reg [`ADCSQ_RES_W-1:0] O_SAMPLE_RESULT,
   output reg O_IRQ,
   output reg O_DMA_REQ
);
   ////////////////////////////////////////////////////////////////////////////
   // states
   localparam ST_OFF = 2'b00;
   localparam ST_SETTLE = 2'b01;
   localparam ST_IDLE = 2'b10;
   localparam ST_CONV = 2'b11;

   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [1:0] div_ff;
   reg [1:0] nxt_div;
   reg [SETTLE_W-1:0] settle_ff;
   reg [SETTLE_W-1:0] nxt_settle;
   reg [TMO_W-1:0] tmo_ff;
   reg [TMO_W-1:0] nxt_tmo;
   reg nxt_go;
   reg nxt_flag;
   reg nxt_start;
   reg nxt_tout;
   reg [`ADCSQ_RES_W-1:0] nxt_result;
   wire core_done;
   wire [`ADCSQ_RAW_W-1:0] core_data;
   wire finish;

   ////////////////////////////////////////////////////////////////////////////
   // analog core runs on its own clock, so done and data are resynchronised
   adcsq_sync3 #(
      .W(`ADCSQ_RAW_W + 1)
   ) u_sync (
      .i_clk(I_CLK_SYS),
      .i_rst(I_SYS_RST),
      .i_d({I_CORE_DONE, I_CORE_DATA}),
      .o_q({core_done, core_data})
   );

   // completion seen only once the start strobe has dropped; timeout avoids lockup
   assign finish = (state_ff == ST_CONV) && !O_CORE_START
      && (core_done || tmo_ff == {TMO_W{1'b0}});

   ////////////////////////////////////////////////////////////////////////////
   // sequencer next state
   always @* begin
      nxt_state = state_ff;
      nxt_div = div_ff;
      nxt_settle = settle_ff;
      nxt_tmo = tmo_ff;
      nxt_go = O_CONVERSION_GO;
      nxt_start = 1'b0;
      nxt_tout = O_TIMEOUT;
      nxt_result = O_SAMPLE_RESULT;
      nxt_flag = O_CONVERSION_DONE_FLAG;
      if (I_DONE_FLAG_CLR) begin
         nxt_flag = 1'b0;
      end
      case (state_ff)
         ST_OFF: begin
            // regulator goes first, converter waits for the delay
            if (I_CONVERTER_POWER_ON) begin
               nxt_state = ST_SETTLE;
               nxt_div = 2'h0;
               nxt_settle = I_REGULATOR_SETTLE_COUNT;
            end
         end
         ST_SETTLE: begin
            // one count per four clocks
            nxt_div = div_ff + 2'h1;
            if (div_ff == `ADCSQ_SETTLE_DIV) begin
               if (settle_ff == {SETTLE_W{1'b0}}) begin
                  nxt_state = ST_IDLE;
               end else begin
                  nxt_settle = settle_ff - {{(SETTLE_W-1){1'b0}}, 1'b1};
               end
            end
         end
         ST_IDLE: begin
            // go accepted only when idle, so no second launch
            if (I_CONVERSION_GO_WR) begin
               nxt_state = ST_CONV;
               nxt_go = 1'b1;
               nxt_start = 1'b1;
               nxt_tout = 1'b0;
               nxt_tmo = `ADCSQ_CONV_TMO;
            end
         end
         ST_CONV: begin
            nxt_tmo = tmo_ff - {{(TMO_W-1){1'b0}}, 1'b1};
            if (finish) begin
               // go clears, flag sets, result left aligned
               nxt_state = ST_IDLE;
               nxt_go = 1'b0;
               nxt_flag = 1'b1; // set wins over a same-cycle clear
               nxt_tout = !core_done;
               nxt_result = {core_data, {(`ADCSQ_RES_W-`ADCSQ_RAW_W){1'b0}}};
            end
         end
         default: begin
            nxt_state = ST_OFF;
         end
      endcase
      // power-off aborts the sequence, go and start (flag, result and timeout keep their values) and rearms the full delay
      if (!I_CONVERTER_POWER_ON) begin
         nxt_state = ST_OFF;
         nxt_go = 1'b0;
         nxt_start = 1'b0;
         nxt_settle = {SETTLE_W{1'b0}};
         nxt_div = 2'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer registers and registered outputs
   always @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         state_ff <= ST_OFF;
         div_ff <= 2'h0;
         settle_ff <= {SETTLE_W{1'b0}};
         tmo_ff <= {TMO_W{1'b0}};
         O_CONVERSION_GO <= 1'b0;
         O_CONVERSION_DONE_FLAG <= 1'b0;
         O_CORE_START <= 1'b0;
         O_TIMEOUT <= 1'b0;
         O_SAMPLE_RESULT <= {`ADCSQ_RES_W{1'b0}};
         O_REGULATOR_EN <= 1'b0;
         O_CONVERTER_EN <= 1'b0;
         O_READY <= 1'b0;
         O_IRQ <= 1'b0;
         O_DMA_REQ <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         div_ff <= nxt_div;
         settle_ff <= nxt_settle;
         tmo_ff <= nxt_tmo;
         O_CONVERSION_GO <= nxt_go;
         O_CONVERSION_DONE_FLAG <= nxt_flag;
         O_CORE_START <= nxt_start;
         O_TIMEOUT <= nxt_tout;
         O_SAMPLE_RESULT <= nxt_result;
         O_REGULATOR_EN <= (nxt_state != ST_OFF);
         O_CONVERTER_EN <= nxt_state[1]; // idle or converting only
         O_READY <= (nxt_state == ST_IDLE);
         O_IRQ <= nxt_flag && I_IRQ_MASK;
         O_DMA_REQ <= (state_ff == ST_CONV) && finish && I_DMA_ENABLE; // pulse
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // analog settings registered toward the core
   always @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_CHANNEL_SELECT <= 3'h0;
         O_SINGLE_ENDED_SELECT <= 1'b0;
         O_INPUT_ATTENUATION <= 2'h0;
         O_LEVEL_SHIFTER_ON <= 1'b0;
         O_SHIFTER_COMMON_MODE <= 4'h0;
      end else begin
         // settings frozen while converting so the sample is not disturbed
         if (state_ff != ST_CONV) begin
            O_CHANNEL_SELECT <= I_CHANNEL_SELECT;
            O_SINGLE_ENDED_SELECT <= I_SINGLE_ENDED_SELECT;
            O_INPUT_ATTENUATION <= I_INPUT_ATTENUATION;
            O_LEVEL_SHIFTER_ON <= I_LEVEL_SHIFTER_ON;
            O_SHIFTER_COMMON_MODE <= I_SHIFTER_COMMON_MODE;
         end
      end
   end
endmodule // adcsq_top

// ===== adcsq_asserts.sv
// port checks for the converter sequencing control block
`timescale 1ns/10ps
module adcsq_asserts (
   // clock, reset and inputs
   input wire I_CLK_SYS, I_SYS_RST, I_CONVERTER_POWER_ON, I_CONVERSION_GO_WR, I_IRQ_MASK,
   // outputs
   input wire O_REGULATOR_EN, O_CONVERTER_EN, O_CORE_START, O_CONVERSION_GO, O_READY,
   input wire O_CONVERSION_DONE_FLAG, O_TIMEOUT, O_IRQ, O_DMA_REQ,
   input wire [15:0] O_SAMPLE_RESULT
);
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (I_SYS_RST);
   ////////////////////////////////////////
   // power sequencing
   property p_reg_first; O_CONVERTER_EN |-> O_REGULATOR_EN; endproperty
   a_reg_first: assert property (p_reg_first) else $error("converter before regulator");
   property p_off;
      !I_CONVERTER_POWER_ON |=> !O_REGULATOR_EN && !O_CONVERTER_EN && !O_CONVERSION_GO;
   endproperty
   a_off: assert property (p_off) else $error("power off not immediate");
   // start and refusal
   property p_start;
      I_CONVERSION_GO_WR && O_READY && I_CONVERTER_POWER_ON |=> O_CONVERSION_GO && O_CORE_START;
   endproperty
   a_start: assert property (p_start) else $error("go write not taken");
   property p_refuse; I_CONVERSION_GO_WR && !O_READY |=> !O_CORE_START; endproperty
   a_refuse: assert property (p_refuse) else $error("busy go write started core");
   // completion effects; a power-off drop of go is excluded through the past level
   property p_done;
      $fell(O_CONVERSION_GO) && $past(I_CONVERTER_POWER_ON) && !O_TIMEOUT |-> O_CONVERSION_DONE_FLAG;
   endproperty
   a_done: assert property (p_done) else $error("go fell without done flag");
   property p_irq; (O_CONVERSION_DONE_FLAG && I_IRQ_MASK) [*2] |-> O_IRQ; endproperty
   a_irq: assert property (p_irq) else $error("unmasked flag without irq");
   property p_align; O_SAMPLE_RESULT[5:0] == 6'h00; endproperty
   a_align: assert property (p_align) else $error("result not left aligned");
   property p_dma; O_DMA_REQ |-> O_CONVERSION_DONE_FLAG && !O_CONVERSION_GO; endproperty
   a_dma: assert property (p_dma) else $error("dma request without completion");
endmodule // adcsq_asserts

// ===== adcsq_core_model.sv
// behavioural analog core answering start pulses after a chosen latency
`timescale 1ns/10ps
module adcsq_core_model (
   input wire clk, start, go,
   input wire [7:0] lat,
   input wire [9:0] val,
   output logic done = 1'b0,
   output logic [9:0] data = 10'h155
);
   int n = 0;
   // count latency, then hold done and data until go falls
   always @(posedge clk) begin
      if (start) n <= lat;
      else if (n > 1) n <= n - 1;
      else if (n == 1) begin
         n <= 0;
         done <= go;
         data <= val;
      end
      // released data wanders so a stale capture cannot pass
      if (!go && done) begin
         done <= 1'b0;
         data <= ~data;
      end
   end
endmodule // adcsq_core_model

// ===== tb_adcsq_top.sv
// self-checking bench for the converter sequencing control block
`timescale 1ns/10ps
module tb_adcsq_top;
   logic clk, rst, pwr, gow, clr, msk, dmae, se, lso, cdone;
   logic [7:0] cnt, lat;
   logic [2:0] ch;
   logic [1:0] att;
   logic [3:0] cm;
   logic [9:0] val, cdata;
   wire reg_en, cnv_en, cst, go, flag, rdy, irq, dma, ose, olso, tout;
   logic [10:0] sv;
   wire [2:0] och;
   wire [1:0] oatt;
   wire [3:0] ocm;
   wire [15:0] res;
   int errors = 0, num_checks = 0, starts = 0, dmas = 0, t, s, d;
   adcsq_top adcsq_top_inst (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_CONVERTER_POWER_ON(pwr),
      .I_REGULATOR_SETTLE_COUNT(cnt), .I_CONVERSION_GO_WR(gow), .I_DONE_FLAG_CLR(clr),
      .I_IRQ_MASK(msk), .I_DMA_ENABLE(dmae), .I_CHANNEL_SELECT(ch), .I_SINGLE_ENDED_SELECT(se),
      .I_INPUT_ATTENUATION(att), .I_LEVEL_SHIFTER_ON(lso), .I_SHIFTER_COMMON_MODE(cm),
      .I_CORE_DONE(cdone), .I_CORE_DATA(cdata), .O_REGULATOR_EN(reg_en), .O_CONVERTER_EN(cnv_en),
      .O_CORE_START(cst), .O_CHANNEL_SELECT(och), .O_SINGLE_ENDED_SELECT(ose),
      .O_INPUT_ATTENUATION(oatt), .O_LEVEL_SHIFTER_ON(olso), .O_SHIFTER_COMMON_MODE(ocm),
      .O_CONVERSION_GO(go), .O_CONVERSION_DONE_FLAG(flag), .O_READY(rdy), .O_TIMEOUT(tout),
      .O_SAMPLE_RESULT(res), .O_IRQ(irq), .O_DMA_REQ(dma));
   adcsq_core_model adcsq_core_model_inst (.clk(clk), .start(cst), .go(go), .lat(lat),
      .val(val), .done(cdone), .data(cdata));
   // clock and pulse counters
   initial begin clk = 0; forever #2 clk = ~clk; end
   always @(posedge clk) begin starts <= starts + cst; dmas <= dmas + dma; end
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      num_checks++;
      if (g !== e) begin errors++; $display("mismatch %s expected %h seen %h", n, e, g); end
   endtask
   task automatic summarize;
      if (errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // power up and time the settle delay, which must be at least four clocks per count
   task automatic power_up(logic [7:0] c);
      @(posedge clk); cnt <= c; pwr <= 1;
      repeat (2) @(posedge clk);
      #1 chk("regulator_converter", 2'h2, {reg_en, cnv_en});
      t = 0;
      while (rdy !== 1'b1 && t < 4 * c + 20) begin @(posedge clk); #1 t++; end
      chk("settle_min", 1, t >= 4 * c);
      chk("ready_enabled", 2'h3, {rdy, cnv_en});
   endtask
   // one manual conversion with random settings; a second go is sent while busy
   task automatic convert(bit abort);
      @(posedge clk); ch <= $urandom; se <= $urandom; att <= $urandom; lso <= $urandom;
      cm <= $urandom; msk <= $urandom; dmae <= $urandom; val <= $urandom; lat <= 1 + $urandom % 20;
      repeat (2) @(posedge clk); gow <= 1; s = starts; d = dmas;
      @(posedge clk); gow <= 0;
      #1 chk("go", 1, go);
      chk("settings", {ch, se, att, lso, cm}, {och, ose, oatt, olso, ocm});
      sv = {ch, se, att, lso, cm};
      // settings moved mid-conversion must not reach the core until it finishes
      @(posedge clk); gow <= 1; ch <= ch + 3'h1;
      @(posedge clk); gow <= 0;
      if (abort) begin
         pwr <= 0;
         repeat (2) @(posedge clk);
         #1 chk("off", 0, {reg_en, cnv_en, go});
         return;
      end
      t = 0;
      // the next request waits until go reads back low
      while (go === 1'b1 && t < 100) begin @(posedge clk); #1 t++; end
      chk("done_flag", 1, flag);
      chk("timeout", 0, tout);
      chk("frozen", sv, {och, ose, oatt, olso, ocm});
      chk("result", {val, 6'h00}, res);
      chk("irq", msk, irq);
      @(posedge clk); clr <= 1;
      #1 chk("starts", s + 1, starts);
      chk("dma", d + dmae, dmas);
      @(posedge clk); clr <= 0;
      repeat (2) @(posedge clk);
      #1 chk("cleared", 0, {flag, irq});
   endtask
   // main sequence
   initial begin
      rst = 1; pwr = 0; gow = 0; clr = 0; msk = 0; dmae = 0; se = 0; lso = 0;
      cnt = 0; lat = 1; ch = 0; att = 0; cm = 0; val = 0;
      void'($urandom(34311));
      repeat (20) @(posedge clk); rst <= 0;
      power_up(8'h40);
      repeat (6) convert(0);
      convert(1);
      power_up($urandom % 8);
      repeat (3) convert(0);
      @(posedge clk); pwr <= 0;
      summarize;
   end
   // watchdog
   initial begin #100000; errors++; summarize; end
endmodule // tb_adcsq_top
bind adcsq_top adcsq_asserts adcsq_asserts_inst (.*);
